// file: logic/tlvic_map.vh
`ifndef TLVIC_MAP_VH
`define TLVIC_MAP_VH
// Register addresses on the special function register bus
`define TLVIC_ADDR_EN      8'hA8
`define TLVIC_ADDR_PRI     8'hB8
`define TLVIC_ADDR_XEN1    8'hE6
`define TLVIC_ADDR_XEN2    8'hE7
`define TLVIC_ADDR_XPRI1   8'hF6
`define TLVIC_ADDR_XPRI2   8'hF7
// Reset values
`define TLVIC_RST_EN       8'h00
`define TLVIC_RST_PRI      8'h80
`define TLVIC_RST_EXT      8'h00
// Field positions and masks
`define TLVIC_GIE_BIT      7
`define TLVIC_PRI_UNUSED   8'h80
`define TLVIC_EXT1_MASK    8'hFD
`define TLVIC_EXT2_MASK    8'h3B
// Vector arithmetic
`define TLVIC_VEC_RESET    16'h0000
`define TLVIC_VEC_BASE     16'h0003
`define TLVIC_VEC_SHIFT    3
`define TLVIC_NSRC         21
`define TLVIC_ORD_W        5
// Sources cleared by hardware on vectoring: orders 0..3
`define TLVIC_HWCLR_MASK   21'h00_000F
// Orders with no source
`define TLVIC_RSVD_MASK    21'h02_0100
// Timing in system clocks
`define TLVIC_DETECT_CYC   1
`define TLVIC_CALL_CYC     3'd5
`endif

// file: logic/tlvic_arbiter.v
`timescale 1ns/1ps
`include "tlvic_map.vh"
// Fixed-order two-level pick; lowest order wins within a level
module tlvic_arbiter #(
   parameter NSRC  = `TLVIC_NSRC,
   parameter ORD_W = `TLVIC_ORD_W
) (
   // Requests
   input  wire [NSRC-1:0]  i_req,
   input  wire [NSRC-1:0]  i_high,
   // Result
   output reg              o_valid,
   output reg              o_is_high,
   output reg  [ORD_W-1:0] o_order
);
   integer k;
   reg     found_hi;
   reg     found_lo;
   reg [ORD_W-1:0] ord_hi;
   reg [ORD_W-1:0] ord_lo;
   always @* begin
      found_hi = 1'b0;
      found_lo = 1'b0;
      ord_hi   = {ORD_W{1'b0}};
      ord_lo   = {ORD_W{1'b0}};
      // Descending scan so the smallest order is the last to win
      for (k = NSRC - 1; k >= 0; k = k - 1) begin
         if (i_req[k] && i_high[k]) begin
            found_hi = 1'b1;
            ord_hi   = k[ORD_W-1:0];
         end
         if (i_req[k] && !i_high[k]) begin
            found_lo = 1'b1;
            ord_lo   = k[ORD_W-1:0];
         end
      end
      o_valid   = found_hi | found_lo;
      o_is_high = found_hi;
      o_order   = found_hi ? ord_hi : ord_lo;
   end
endmodule

// file: logic/tlvic_sync2.v
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of pin levels
module tlvic_sync2 #(
   parameter W = 1
) (
   // Clock, reset, enable
   input  wire         i_core_clk,
   input  wire         i_rst,
   input  wire         i_ce,
   // Data
   input  wire [W-1:0] i_async,
   output reg  [W-1:0] o_sync
);
   reg [W-1:0] meta;
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         meta   <= {W{1'b0}};
         o_sync <= {W{1'b0}};
      end else if (i_ce) begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule

// file: logic/tlvic_ctrl.v
`timescale 1ns/1ps
`include "tlvic_map.vh"
module tlvic_ctrl #(
   parameter NSRC  = `TLVIC_NSRC,
   parameter ORD_W = `TLVIC_ORD_W
) (
   // Clock, reset, enable
   input  wire             i_core_clk,
   input  wire             i_rst,
   input  wire             i_ce,
   // Trigger pulses from peripherals on the core clock, one bit per order
   input  wire [NSRC-1:0]  i_periph_set,
   // Software flag clears from peripheral registers, one bit per order
   input  wire [NSRC-1:0]  i_flag_clr,
   // Software flag sets (simulated interrupt), one bit per order
   input  wire [NSRC-1:0]  i_flag_swset,
   // Level-sensitive external interrupt 2 pin, active high
   input  wire             i_ext_level_irq_two,
   // Register bus from the core
   input  wire [7:0]       i_sfr_addr,
   input  wire             i_sfr_wr,
   input  wire [7:0]       i_sfr_wdata,
   input  wire             i_sfr_rd,
   output reg  [7:0]       o_sfr_rdata,
   output wire             o_sfr_hit,
   // Instruction sequencer handshake
   input  wire             i_insn_boundary,
   input  wire             i_insn_multi_cycle,
   input  wire             i_return_done,
   input  wire             i_flash_stall,
   input  wire             i_call_ack,
   output wire             o_irq_req,
   output reg  [15:0]      o_irq_vector,
   output reg              o_call_busy,
   // State visible to the core and peripherals
   output reg  [NSRC-1:0]  o_pending,
   output reg  [1:0]       o_in_service
);
   localparam ST_IDLE = 2'b00;
   localparam ST_CALL = 2'b01;
   localparam ST_HOLD = 2'b10;

   reg  [7:0]       irq_enable_reg;
   reg  [7:0]       irq_priority_reg;
   reg  [7:0]       ext_enable_reg_one;
   reg  [7:0]       ext_enable_reg_two;
   reg  [7:0]       ext_priority_reg_one;
   reg  [7:0]       ext_priority_reg_two;
   reg  [1:0]       state;
   reg  [2:0]       call_cnt;
   reg  [ORD_W-1:0] taken_order;
   reg              taken_high;
   reg              ret_block;
   reg              en_shadow;
   reg  [NSRC-1:0]  next_pending;
   reg  [7:0]       next_rdata;
   wire [NSRC-1:0]  src_enable;
   wire [NSRC-1:0]  src_high;
   wire [NSRC-1:0]  src_req;
   wire [NSRC-1:0]  level_ok;
   wire             level_two_sync;
   wire             arb_valid;
   wire             arb_high;
   wire [ORD_W-1:0] arb_order;
   wire             gie_eff;
   wire             can_take;
   wire             take;
   wire             wr_en;
   wire             wr_pri;
   wire             wr_e1;
   wire             wr_e2;
   wire             wr_p1;
   wire             wr_p2;

   tlvic_sync2 #(
      .W (1)
   ) u_sync (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_ce       (i_ce),
      .i_async    (i_ext_level_irq_two),
      .o_sync     (level_two_sync)
   );

   assign wr_en  = i_sfr_wr && (i_sfr_addr == `TLVIC_ADDR_EN);
   assign wr_pri = i_sfr_wr && (i_sfr_addr == `TLVIC_ADDR_PRI);
   assign wr_e1  = i_sfr_wr && (i_sfr_addr == `TLVIC_ADDR_XEN1);
   assign wr_e2  = i_sfr_wr && (i_sfr_addr == `TLVIC_ADDR_XEN2);
   assign wr_p1  = i_sfr_wr && (i_sfr_addr == `TLVIC_ADDR_XPRI1);
   assign wr_p2  = i_sfr_wr && (i_sfr_addr == `TLVIC_ADDR_XPRI2);
   assign o_sfr_hit = wr_en | wr_pri | wr_e1 | wr_e2 | wr_p1 | wr_p2 |
                      (i_sfr_rd && ((i_sfr_addr == `TLVIC_ADDR_EN) || (i_sfr_addr == `TLVIC_ADDR_PRI) ||
                                    (i_sfr_addr == `TLVIC_ADDR_XEN1) || (i_sfr_addr == `TLVIC_ADDR_XEN2) ||
                                    (i_sfr_addr == `TLVIC_ADDR_XPRI1) || (i_sfr_addr == `TLVIC_ADDR_XPRI2)));

   // Register writes; bit-addressable writes arrive as read-modify-write bytes
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_enable_reg       <= `TLVIC_RST_EN;
         irq_priority_reg     <= `TLVIC_RST_PRI;
         ext_enable_reg_one   <= `TLVIC_RST_EXT;
         ext_enable_reg_two   <= `TLVIC_RST_EXT;
         ext_priority_reg_one <= `TLVIC_RST_EXT;
         ext_priority_reg_two <= `TLVIC_RST_EXT;
      end else if (i_ce) begin
         if (wr_en)
            irq_enable_reg <= i_sfr_wdata;
         if (wr_pri)
            irq_priority_reg <= i_sfr_wdata | `TLVIC_PRI_UNUSED;
         if (wr_e1)
            ext_enable_reg_one <= i_sfr_wdata & `TLVIC_EXT1_MASK;
         if (wr_e2)
            ext_enable_reg_two <= i_sfr_wdata & `TLVIC_EXT2_MASK;
         if (wr_p1)
            ext_priority_reg_one <= i_sfr_wdata & `TLVIC_EXT1_MASK;
         if (wr_p2)
            ext_priority_reg_two <= i_sfr_wdata & `TLVIC_EXT2_MASK;
      end
   end

   always @* begin
      case (i_sfr_addr)
         `TLVIC_ADDR_EN:    next_rdata = irq_enable_reg;
         `TLVIC_ADDR_PRI:   next_rdata = irq_priority_reg | `TLVIC_PRI_UNUSED;
         `TLVIC_ADDR_XEN1:  next_rdata = ext_enable_reg_one;
         `TLVIC_ADDR_XEN2:  next_rdata = ext_enable_reg_two;
         `TLVIC_ADDR_XPRI1: next_rdata = ext_priority_reg_one;
         `TLVIC_ADDR_XPRI2: next_rdata = ext_priority_reg_two;
         default:          next_rdata = 8'h00;
      endcase
   end

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst)
         o_sfr_rdata <= 8'h00;
      else if (i_ce && i_sfr_rd)
         o_sfr_rdata <= next_rdata;
   end

   // Order-indexed enable and priority maps; one bit each per source
   assign src_enable = {ext_enable_reg_two[5:3], 1'b0, ext_enable_reg_two[1:0],
                        ext_enable_reg_one[7:2], 1'b0, ext_enable_reg_one[0],
                        irq_enable_reg[6:0]};
   assign src_high   = {ext_priority_reg_two[5:3], 1'b0, ext_priority_reg_two[1:0],
                        ext_priority_reg_one[7:2], 1'b0, ext_priority_reg_one[0],
                        irq_priority_reg[6:0]};

   // Pending flags; a set in the same cycle as a clear wins
   always @* begin
      next_pending = o_pending;
      next_pending = next_pending & ~i_flag_clr;
      if (take)
         next_pending = next_pending & ~(`TLVIC_HWCLR_MASK & ({{(NSRC-1){1'b0}}, 1'b1} << arb_order));
      next_pending = next_pending | i_periph_set | i_flag_swset;
      next_pending[15] = level_two_sync; // Level source tracks its pin
      next_pending = next_pending & ~`TLVIC_RSVD_MASK;
   end

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst)
         o_pending <= {NSRC{1'b0}};
      else if (i_ce)
         o_pending <= next_pending;
   end

   // Global enable bit as seen at the start of the current instruction
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst)
         en_shadow <= 1'b0;
      else if (i_ce && i_insn_boundary)
         en_shadow <= irq_enable_reg[`TLVIC_GIE_BIT];
   end

   // Request gating: global, per source, and the level already in service
   // Shadow keeps the arbiter valid so a leaked request still gets its own vector
   assign gie_eff  = irq_enable_reg[`TLVIC_GIE_BIT] | (en_shadow & !i_insn_multi_cycle);
   assign src_req  = o_pending & src_enable & {NSRC{gie_eff}};
   assign level_ok = o_in_service[1] ? {NSRC{1'b0}} :
                     o_in_service[0] ? src_high : {NSRC{1'b1}};

   tlvic_arbiter #(
      .NSRC  (NSRC),
      .ORD_W (ORD_W)
   ) u_arb (
      .i_req     (src_req & level_ok),
      .i_high    (src_high),
      .o_valid   (arb_valid),
      .o_is_high (arb_high),
      .o_order   (arb_order)
   );

   // A clearing instruction followed by a single-cycle one may still let the
   // request through; a multi-cycle follower blocks it
   // The boundary that ends the one instruction after a return may take at once
   assign can_take = (state == ST_IDLE) && !i_return_done && !i_flash_stall && i_insn_boundary;
   assign take     = i_ce && can_take && arb_valid;
   assign o_irq_req = (state == ST_IDLE) && arb_valid && !ret_block;

   // Vectoring sequencer and in-service markers
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state        <= ST_IDLE;
         call_cnt     <= 3'd0;
         taken_order  <= {ORD_W{1'b0}};
         taken_high   <= 1'b0;
         o_irq_vector <= `TLVIC_VEC_RESET;
         o_call_busy  <= 1'b0;
         o_in_service <= 2'b00;
         ret_block    <= 1'b0;
      end else if (i_ce) begin
         if (i_return_done) begin
            // Highest active level retires first
            if (o_in_service[1])
               o_in_service[1] <= 1'b0;
            else
               o_in_service[0] <= 1'b0;
            ret_block <= 1'b1;
         end else if (ret_block && i_insn_boundary && !i_flash_stall) begin
            ret_block <= 1'b0;
         end
         case (state)
            ST_IDLE: begin
               if (take) begin
                  taken_order  <= arb_order;
                  taken_high   <= arb_high;
                  o_irq_vector <= `TLVIC_VEC_BASE + ({{(16-ORD_W){1'b0}}, arb_order} << `TLVIC_VEC_SHIFT);
                  call_cnt     <= `TLVIC_CALL_CYC - 3'd1;
                  o_call_busy  <= 1'b1;
                  state        <= ST_CALL;
               end
            end
            ST_CALL: begin
               if (!i_flash_stall) begin
                  if (call_cnt == 3'd1) begin
                     if (taken_high)
                        o_in_service[1] <= 1'b1;
                     else
                        o_in_service[0] <= 1'b1;
                     state <= ST_HOLD;
                  end
                  call_cnt <= call_cnt - 3'd1;
               end
            end
            ST_HOLD: begin
               o_call_busy <= 1'b0;
               if (i_call_ack || !i_flash_stall)
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule

// file: dv/tlvic_ctrl_monitor.sv
`timescale 1ns/1ps
module tlvic_ctrl_monitor #(
   parameter NSRC = 21
) (
   // Clock and reset
   input wire            i_core_clk,
   input wire            i_rst,
   // Watched inputs
   input wire            i_ce,
   input wire [NSRC-1:0] i_periph_set,
   input wire            i_flash_stall,
   input wire            i_insn_boundary,
   // Watched outputs
   input wire [15:0]     o_irq_vector,
   input wire            o_call_busy,
   input wire [NSRC-1:0] o_pending,
   input wire [1:0]      o_in_service
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // Sticky flags with no hardware clear and no level source
   localparam [20:0] STICKY = 21'h1D_7EF0;

   AST_FLAG_SET: assert property (
      i_ce |=> ($past(i_periph_set) & STICKY & ~o_pending) == 0)
      else $error("trigger did not set its flag");
   AST_RSVD: assert property (
      o_pending[8] == 1'b0 && o_pending[17] == 1'b0)
      else $error("reserved order shows a flag");
   AST_TAKE_AT_BOUNDARY: assert property (
      $rose(o_call_busy) |-> $past(i_insn_boundary))
      else $error("call started inside an instruction");
   AST_VEC_FORM: assert property (
      $rose(o_call_busy) |-> o_irq_vector[2:0] == 3'h3 && o_irq_vector <= 16'h00A3)
      else $error("vector off the table");
   AST_CALL_LEN: assert property (
      $rose(o_call_busy) |-> o_call_busy [*5] ##1 !o_call_busy)
      else $error("call length not five cycles");
   AST_IN_SERVICE: assert property (
      $rose(o_call_busy) |-> ##4 (o_in_service != $past(o_in_service, 4)))
      else $error("in-service marker not set by call");
   AST_HW_CLEAR: assert property (
      ($rose(o_call_busy) && o_irq_vector < 16'h0023) |-> !o_pending[o_irq_vector[4:3]])
      else $error("flag not cleared on vectoring");
   AST_STALL: assert property (
      (i_flash_stall && !o_call_busy) |=> !o_call_busy)
      else $error("call taken during stall");
   AST_HIGH_KEEP: assert property (
      o_in_service[1] |=> !$rose(o_call_busy))
      else $error("high level routine preempted");
endmodule

bind tlvic_ctrl tlvic_ctrl_monitor #(.NSRC(NSRC)) u_mon (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
   .i_periph_set(i_periph_set), .i_flash_stall(i_flash_stall),
   .i_insn_boundary(i_insn_boundary), .o_irq_vector(o_irq_vector),
   .o_call_busy(o_call_busy), .o_pending(o_pending), .o_in_service(o_in_service)
);

// file: dv/tlvic_seq_model.sv
`timescale 1ns/1ps
// Sequencer with fixed-length instructions
module tlvic_seq_model (
   // Clock and reset
   input  wire       i_core_clk,
   input  wire       i_rst,
   // Controller side
   input  wire       i_call_busy,
   input  wire [3:0] i_insn_len,
   output reg        o_insn_boundary,
   output reg        o_call_ack
);
   reg [3:0] cnt;
   reg [2:0] ccnt;
   always @(negedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= 4'h0;
         ccnt <= 3'h0;
         o_insn_boundary <= 1'b0;
         o_call_ack <= 1'b0;
      end else if (i_call_busy) begin
         // No instruction ends while the call runs
         cnt <= 4'h0;
         ccnt <= ccnt + 3'h1;
         o_insn_boundary <= 1'b0;
         o_call_ack <= (ccnt == 3'h4);
      end else begin
         cnt <= (cnt + 4'h1 == i_insn_len) ? 4'h0 : cnt + 4'h1;
         ccnt <= 3'h0;
         o_insn_boundary <= (cnt + 4'h1 == i_insn_len);
         o_call_ack <= 1'b0;
      end
   end
endmodule

// file: dv/test_two_level_vectored_irq_controller.sv
`timescale 1ns/1ps
module test_two_level_vectored_irq_controller;
   reg         clk;
   reg         rst;
   reg  [20:0] pset;
   reg  [20:0] pclr;
   reg  [20:0] swset;
   reg  [7:0]  addr;
   reg  [7:0]  wdata;
   reg         wr;
   reg         rd;
   reg         ret;
   reg         stall;
   reg  [3:0]  len;
   reg         multi;
   reg         lvl;
   wire        hit;
   wire [7:0]  rdata;
   wire        bnd;
   wire        ack;
   wire        req;
   wire [15:0] vec;
   wire        busy;
   wire [20:0] pend;
   wire [1:0]  isv;
   integer     err_total;
   integer     num_checks;
   integer     cyc;

   // Followers are multi-cycle, so a disable never leaks a call
   tlvic_ctrl dut_u (
      .i_core_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_periph_set(pset),
      .i_flag_clr(pclr), .i_flag_swset(swset), .i_ext_level_irq_two(lvl),
      .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata), .i_sfr_rd(rd),
      .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_insn_boundary(bnd),
      .i_insn_multi_cycle(multi), .i_return_done(ret), .i_flash_stall(stall),
      .i_call_ack(ack), .o_irq_req(req), .o_irq_vector(vec), .o_call_busy(busy),
      .o_pending(pend), .o_in_service(isv)
   );
   tlvic_seq_model seq_u (
      .i_core_clk(clk), .i_rst(rst), .i_call_busy(busy), .i_insn_len(len),
      .o_insn_boundary(bnd), .o_call_ack(ack)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 4000) begin
         err_total = err_total + 1;
         print_verdict;
      end
   end

   task print_verdict;
      $display("checks %0d, errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [20:0] s, e);
      num_checks = num_checks + 1;
      if (s !== e) begin
         err_total = err_total + 1;
         $display("Error at %0t: saw %h, expected %h", $time, s, e);
      end
   endtask
   task wr_reg(input logic [7:0] a, d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      #1;
      chk(hit, (a == 8'hA8) || (a == 8'hB8) || (a == 8'hE6));
      @(negedge clk);
      wr = 1'b0;
   endtask
   task rd_reg(input logic [7:0] a, e);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      chk(rdata, e);
   endtask
   // Kind 0 trigger, 1 software set, 2 software clear
   task evt(input integer k, input logic [20:0] m);
      @(negedge clk);
      if (k == 0) pset = m;
      else if (k == 1) swset = m;
      else pclr = m;
      @(negedge clk);
      pset = 21'h00_0000;
      swset = 21'h00_0000;
      pclr = 21'h00_0000;
   endtask
   task call(input logic [15:0] v);
      integer n;
      n = 0;
      while (busy !== 1'b1 && n < 60) begin
         @(negedge clk);
         n = n + 1;
      end
      chk(busy, 1'b1);
      chk(vec, v);
      repeat (6) @(negedge clk);
   endtask
   task irq_return_insn;
      @(negedge clk);
      ret = 1'b1;
      @(negedge clk);
      ret = 1'b0;
   endtask

   initial begin
      err_total = 0;
      num_checks = 0;
      cyc = 0;
      rst = 1'b1;
      {pset, pclr, swset} = 63'h0;
      {addr, wdata, wr, rd, ret, stall} = 20'h0_0000;
      len = 4'h3;
      multi = 1'b1;
      lvl = 1'b0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      rd_reg(8'hA8, 8'h00);
      rd_reg(8'hB8, 8'h80);
      lvl = 1'b1;
      repeat (4) @(negedge clk);
      chk(pend[15], 1'b1);
      lvl = 1'b0;
      repeat (4) @(negedge clk);
      chk(pend[15], 1'b0);
      wr_reg(8'hB8, 8'h7F);
      rd_reg(8'hB8, 8'hFF);
      wr_reg(8'hB8, 8'h00);
      rd_reg(8'hB8, 8'h80);
      wr_reg(8'hE6, 8'hFF);
      rd_reg(8'hE6, 8'hFD);
      wr_reg(8'h80, 8'h55);
      rd_reg(8'h80, 8'h00);
      wr_reg(8'hE6, 8'h00);
      evt(0, 21'h00_0002);
      chk(pend[1], 1'b1);
      chk(req, 1'b0);
      wr_reg(8'hA8, 8'h02);
      chk(req, 1'b0);
      wr_reg(8'hA8, 8'h82);
      call(16'h000B);
      chk(pend[1], 1'b0);
      chk(isv, 2'h1);
      irq_return_insn;
      wr_reg(8'hA8, 8'hFF);
      evt(0, 21'h00_0050);
      call(16'h0023);
      repeat (8) @(negedge clk);
      chk(vec, 16'h0023);
      wr_reg(8'hB8, 8'h40);
      call(16'h0033);
      chk(isv, 2'h3);
      chk(pend[6:4], 3'h5);
      evt(2, 21'h00_0050);
      irq_return_insn;
      irq_return_insn;
      repeat (3) @(negedge clk);
      chk(isv, 2'h0);
      evt(1, 21'h00_0020);
      call(16'h002B);
      irq_return_insn;
      call(16'h002B);
      evt(2, 21'h00_0020);
      irq_return_insn;
      stall = 1'b1;
      evt(1, 21'h00_0001);
      repeat (10) @(negedge clk);
      chk(busy, 1'b0);
      stall = 1'b0;
      call(16'h0003);
      chk(pend[0], 1'b0);
      irq_return_insn;
      wr_reg(8'hE6, 8'h01);
      evt(0, 21'h00_0080);
      call(16'h003B);
      evt(2, 21'h00_0080);
      irq_return_insn;
      wr_reg(8'hA8, 8'h7F);
      evt(0, 21'h00_0010);
      repeat (10) @(negedge clk);
      chk(busy, 1'b0);
      print_verdict;
   end
endmodule
